// File: rtl/power_wake_defs.vh
// Purpose: constants for the power and wake control block
// Assumes: 100 MHz core clock, Avalon-MM word addressing
// Notes: bit positions and reset values of the control word
`ifndef POWER_WAKE_DEFS_VH
`define POWER_WAKE_DEFS_VH
`define PWC_ADDR_CTRL 2'h0
`define PWC_ADDR_SIDE 2'h1
`define PWC_BIT_READY 7
`define PWC_BIT_SUSP_HI 6
`define PWC_BIT_SUSP_LO 5
`define PWC_BIT_PHYRST 4
`define PWC_BIT_LANWK 3
`define PWC_BIT_PHYWK 2
`define PWC_BIT_CAUSE_HI 1
`define PWC_BIT_CAUSE_LO 0
`define PWC_SIDE_EEWAKE 0
`define PWC_SIDE_XTAL 1
`define PWC_SIDE_SKIPREF 2
`define PWC_SIDE_RCLR_EN 3
`define PWC_SIDE_RCLR_ST 4
`define PWC_SUSP_RESET 2'h2
`define PWC_SUSP_ZERO 2'h0
`define PWC_SUSP_ONE 2'h1
`define PWC_SUSP_THREE 2'h3
`define PWC_RCLR_EN_RESET 1'h1
`define PWC_CLK_MHZ 100
`define PWC_PHYRST_MIN_MS 4
`define PWC_PHYRST_EXT_MS 128
`endif

// File: rtl/power_wake_control.v
// Purpose: ready flag, suspend select, self-timed phy reset, wake enables and causes
// Assumes: single clock, synchronous active-low reset, Avalon-MM slave
// Notes: external event inputs are double registered before use
// Contract
// R1: ready held low until phy operational
// R2: ready held low during config loading
// R3: suspend select bits 6:5 default 10b
// R4: unconfigured state forces suspend select 10b
// R5: encodings 00..11; states zero, one alike
// R6: software selects only state two unconfigured
// R7: phy reset bit holds reset 4 ms
// R8: phy reset self-clears; writes ignored while set
// R9: setting phy reset drops ready immediately
// R10: analog reference wait extends hold 128 ms
// R11: software sets phy reset after state two
// R12: bit 3 lan wake enable, default 0
// R13: bit 2 phy wake enable, default 0
// R14: resume may clear both wake enables
// R15: cause bits 1:0, write one clears
// R16: bit0 phy wake, bit1 frame wakes
// R17: energy flag from energy-efficient rx/tx wakes
// R18: several cause bits may be set
// R19: cause set only when event enabled
// R20: resume may clear frame cause bit
// R21: no clear with suspend select change
// R22: crystal default reloads on resets
// R23: only device-initiated resumes clear statuses
// R24: ready is read only
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "power_wake_defs.vh"
module power_wake_control #(
  parameter PHYRST_MIN_CYC = `PWC_PHYRST_MIN_MS * `PWC_CLK_MHZ * 1000,
  parameter PHYRST_EXT_CYC = `PWC_PHYRST_EXT_MS * `PWC_CLK_MHZ * 1000
)(
  input wire core_clk_i,
  input wire rst_b_i,
  input wire light_reset_i,
  input wire [1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire config_loading_i,
  input wire dev_unconfigured_i,
  input wire phy_operational_i,
  input wire crystal_default_i,
  input wire resume_done_i,
  input wire resume_by_device_i,
  input wire phy_irq_event_i,
  input wire lan_frame_event_i,
  input wire energy_eff_rx_wake_i,
  input wire energy_eff_tx_wake_i,
  output reg ready_o,
  output reg [1:0] suspend_select_o,
  output reg phy_reset_o,
  output reg crystal_sleep_disable_o,
  output reg lan_wake_enable_o,
  output reg phy_irq_wake_enable_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam NSYNC = 7;

  // an extended hold simply waits longer; the count register covers the longer one
  reg [23:0] hold_cnt_reg;
  reg [2:0] state_reg;
  reg [1:0] suspend_reg;
  reg lan_wk_reg;
  reg phy_wk_reg;
  reg [1:0] cause_reg;
  reg ee_flag_reg;
  reg xtal_reg;
  reg skip_ref_reg;
  reg rclr_en_reg;
  reg rclr_st_reg;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  reg [NSYNC-1:0] sync2_d_reg;
  reg ack_reg;

  wire [NSYNC-1:0] async_in;
  wire [NSYNC-1:0] rise;
  wire loading_s;
  wire unconf_s;
  wire phy_op_s;
  wire resume_s;
  wire dev_res_s;
  wire phy_ev_s;
  wire lan_ev_s;
  wire eerx_s;
  wire eetx_s;
  wire wr_ctrl;
  wire wr_side;
  wire dev_resume;
  wire [23:0] hold_target;

  // returns true when the given byte lane is enabled for this write
  function lane_on;
    input [3:0] be;
    input integer lane;
    begin
      lane_on = be[lane];
    end
  endfunction

  // event and status pins come from other domains, so each passes two flops
  assign async_in = {energy_eff_tx_wake_i, energy_eff_rx_wake_i, lan_frame_event_i,
    phy_irq_event_i, resume_done_i, phy_operational_i, config_loading_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk_i)
      begin
        if (!rst_b_i)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync2_d_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync2_d_reg[gi] <= sync2_reg[gi];
        end
      end
      assign rise[gi] = sync2_reg[gi] & ~sync2_d_reg[gi];
    end
  endgenerate

  // separate synchroniser pair for the two level inputs outside the vector
  reg unconf1_reg;
  reg unconf2_reg;
  reg devres1_reg;
  reg devres2_reg;
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      unconf1_reg <= 1'b0;
      unconf2_reg <= 1'b0;
      devres1_reg <= 1'b0;
      devres2_reg <= 1'b0;
    end
    else
    begin
      unconf1_reg <= dev_unconfigured_i;
      unconf2_reg <= unconf1_reg;
      devres1_reg <= resume_by_device_i;
      devres2_reg <= devres1_reg;
    end
  end

  assign loading_s = sync2_reg[0];
  assign phy_op_s = sync2_reg[1];
  assign resume_s = rise[2];
  assign phy_ev_s = rise[3];
  assign lan_ev_s = rise[4];
  assign eerx_s = rise[5];
  assign eetx_s = rise[6];
  assign unconf_s = unconf2_reg;
  assign dev_res_s = devres2_reg;
  assign dev_resume = resume_s & dev_res_s; // R23

  // a write completes in the cycle where waitrequest is low with the request present
  assign wr_ctrl = avs_write_i & ~avs_waitrequest_o & (avs_address_i == `PWC_ADDR_CTRL);
  assign wr_side = avs_write_i & ~avs_waitrequest_o & (avs_address_i == `PWC_ADDR_SIDE);

  assign hold_target = skip_ref_reg ? PHYRST_MIN_CYC[23:0] : PHYRST_EXT_CYC[23:0]; // R10

  // phy reset sequencer: hold, then wait for the phy to report operational
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_HOLD;
      hold_cnt_reg <= 24'h000000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          hold_cnt_reg <= 24'h000000;
          if (wr_ctrl && lane_on(avs_byteenable_i, 0) && avs_writedata_i[`PWC_BIT_PHYRST])
          begin
            state_reg <= ST_HOLD; // R7
          end
        end
        ST_HOLD:
        begin
          // writes are not looked at here, so a second request is ignored
          hold_cnt_reg <= hold_cnt_reg + 24'h000001; // R8
          if (hold_cnt_reg >= hold_target - 24'h000001)
          begin
            state_reg <= ST_WAIT; // R7
          end
        end
        ST_WAIT:
        begin
          if (phy_op_s)
          begin
            state_reg <= ST_IDLE; // R8
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // control bits that software writes and the resume logic may clear
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      suspend_reg <= `PWC_SUSP_RESET; // R3
      lan_wk_reg <= 1'b0; // R12
      phy_wk_reg <= 1'b0; // R13
      skip_ref_reg <= 1'b0;
      rclr_en_reg <= `PWC_RCLR_EN_RESET;
      rclr_st_reg <= 1'b0;
    end
    else
    begin
      if (unconf_s)
      begin
        suspend_reg <= `PWC_SUSP_RESET; // R4
      end
      else if (wr_ctrl && lane_on(avs_byteenable_i, 0))
      begin
        suspend_reg <= avs_writedata_i[`PWC_BIT_SUSP_HI:`PWC_BIT_SUSP_LO]; // R5
      end
      if (dev_resume && rclr_en_reg)
      begin
        lan_wk_reg <= 1'b0; // R14
        phy_wk_reg <= 1'b0; // R14
      end
      else if (wr_ctrl && lane_on(avs_byteenable_i, 0))
      begin
        lan_wk_reg <= avs_writedata_i[`PWC_BIT_LANWK]; // R12
        phy_wk_reg <= avs_writedata_i[`PWC_BIT_PHYWK]; // R13
      end
      if (wr_side && lane_on(avs_byteenable_i, 0))
      begin
        skip_ref_reg <= avs_writedata_i[`PWC_SIDE_SKIPREF];
        rclr_en_reg <= avs_writedata_i[`PWC_SIDE_RCLR_EN];
        rclr_st_reg <= avs_writedata_i[`PWC_SIDE_RCLR_ST];
      end
    end
  end

  // crystal default is re-captured after either reset, never taken under reset itself
  reg xtal_load_reg;
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      xtal_reg <= 1'b1;
      xtal_load_reg <= 1'b1;
    end
    else if (light_reset_i)
    begin
      xtal_load_reg <= 1'b1; // R22
    end
    else if (xtal_load_reg)
    begin
      xtal_reg <= crystal_default_i; // R22
      xtal_load_reg <= 1'b0;
    end
    else if (wr_side && lane_on(avs_byteenable_i, 0))
    begin
      xtal_reg <= avs_writedata_i[`PWC_SIDE_XTAL];
    end
  end

  // wake causes: events set, write-one clears; a set in the same cycle wins
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      cause_reg <= 2'h0; // R15
      ee_flag_reg <= 1'b0;
    end
    else
    begin
      if (phy_ev_s && phy_wk_reg)
      begin
        cause_reg[0] <= 1'b1; // R16 R19
      end
      else if (wr_ctrl && lane_on(avs_byteenable_i, 0) && avs_writedata_i[`PWC_BIT_CAUSE_LO])
      begin
        cause_reg[0] <= 1'b0; // R15
      end
      if (lan_ev_s && lan_wk_reg)
      begin
        cause_reg[1] <= 1'b1; // R16 R18 R19
      end
      else if (dev_resume && rclr_st_reg)
      begin
        cause_reg[1] <= 1'b0; // R20
      end
      else if (wr_ctrl && lane_on(avs_byteenable_i, 0) && avs_writedata_i[`PWC_BIT_CAUSE_HI])
      begin
        cause_reg[1] <= 1'b0; // R15
      end
      if ((eerx_s && (suspend_reg == `PWC_SUSP_ZERO || suspend_reg == `PWC_SUSP_ONE
          || suspend_reg == `PWC_SUSP_THREE)) || (eetx_s && suspend_reg == `PWC_SUSP_THREE))
      begin
        ee_flag_reg <= 1'b1; // R17
      end
      else if (dev_resume && rclr_st_reg)
      begin
        ee_flag_reg <= 1'b0; // R20
      end
      else if (wr_side && lane_on(avs_byteenable_i, 0) && avs_writedata_i[`PWC_SIDE_EEWAKE])
      begin
        ee_flag_reg <= 1'b0;
      end
    end
  end

  // one wait cycle per access keeps read data registered; unmapped reads give zero
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ack_reg <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      ack_reg <= (avs_read_i | avs_write_i) & avs_waitrequest_o & ~ack_reg;
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o & ~ack_reg);
      avs_readdata_o <= 32'h00000000;
      if (avs_read_i && avs_address_i == `PWC_ADDR_CTRL)
      begin
        avs_readdata_o <= {24'h000000, ready_o, suspend_reg, state_reg != ST_IDLE,
          lan_wk_reg, phy_wk_reg, cause_reg}; // R24
      end
      else if (avs_read_i && avs_address_i == `PWC_ADDR_SIDE)
      begin
        avs_readdata_o <= {27'h0000000, rclr_st_reg, rclr_en_reg, skip_ref_reg,
          xtal_reg, ee_flag_reg};
      end
    end
  end

  // registered outputs; ready falls the cycle the phy reset request is taken
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ready_o <= 1'b0;
      suspend_select_o <= `PWC_SUSP_RESET;
      phy_reset_o <= 1'b1;
      crystal_sleep_disable_o <= 1'b1;
      lan_wake_enable_o <= 1'b0;
      phy_irq_wake_enable_o <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && lane_on(avs_byteenable_i, 0) && avs_writedata_i[`PWC_BIT_PHYRST])
      begin
        ready_o <= 1'b0; // R9
      end
      else
      begin
        ready_o <= (state_reg == ST_IDLE) & ~loading_s & phy_op_s; // R1 R2 R9
      end
      suspend_select_o <= suspend_reg;
      phy_reset_o <= (state_reg == ST_HOLD); // R7
      crystal_sleep_disable_o <= xtal_reg;
      lan_wake_enable_o <= lan_wk_reg;
      phy_irq_wake_enable_o <= phy_wk_reg;
    end
  end
endmodule // power_wake_control

// File: bench/pwc_checker_asserts.sv
// Purpose: assertions on the power and wake block ports
// Assumes: synced inputs act within five edges
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module pwc_checker #(
  parameter PHYRST_MIN_CYC = 20
)(
  input wire core_clk_i,
  input wire rst_b_i,
  input wire light_reset_i,
  input wire [1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_waitrequest_o,
  input wire config_loading_i,
  input wire dev_unconfigured_i,
  input wire crystal_default_i,
  input wire ready_o,
  input wire [1:0] suspend_select_o,
  input wire phy_reset_o,
  input wire crystal_sleep_disable_o,
  input wire lan_wake_enable_o,
  input wire phy_irq_wake_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // control word write taken at this edge
  wire ack = !avs_waitrequest_o;
  wire wr0 = avs_write_i && ack && avs_address_i == 2'h0 && avs_byteenable_i[0];
  wire go_wr = wr0 && avs_writedata_i[4] && ready_o;
  wire lan_wr = wr0 && avs_writedata_i[3];
  wire phy_wr = wr0 && avs_writedata_i[2];
  // hold length counter; a repetition would unroll far too long
  int hold_cnt = 0;
  always @(posedge core_clk_i)
    hold_cnt <= (phy_reset_o && rst_b_i) ? hold_cnt + 1 : 0;
  hold_ready_a: assert property (phy_reset_o |-> !ready_o)
    else $error("ready high in phy reset");
  load_ready_a: assert property (config_loading_i [*5] |-> !ready_o)
    else $error("ready high while loading");
  unconf_susp_a: assert property (dev_unconfigured_i [*5] |-> suspend_select_o == 2'h2)
    else $error("suspend select not forced");
  phy_go_a: assert property (go_wr |-> ##2 !ready_o ##[0:3] phy_reset_o)
    else $error("phy reset start wrong");
  hold_len_a: assert property ($fell(phy_reset_o) |-> hold_cnt >= PHYRST_MIN_CYC)
    else $error("phy reset hold too short");
  // the enable register and its output flop put two edges between write and pin
  lan_en_a: assert property ($rose(lan_wake_enable_o) |-> $past(lan_wr, 2))
    else $error("lan wake enable set unasked");
  phy_en_a: assert property ($rose(phy_irq_wake_enable_o) |-> $past(phy_wr, 2))
    else $error("phy wake enable set unasked");
  // capture one edge after the fall, then the output flop
  xtal_load_a: assert property ($fell(light_reset_i) |-> ##2
    crystal_sleep_disable_o == $past(crystal_default_i, 2))
    else $error("crystal default not reloaded");
  wait_one_a: assert property (ack |=> !ack)
    else $error("waitrequest low too long");
  answer_a: assert property ((avs_read_i || avs_write_i) && !ack |=> ack)
    else $error("bus answer late");
  c_write: cover property (wr0);
  c_hold: cover property ($fell(phy_reset_o));
  c_ready: cover property ($rose(ready_o));
endmodule // pwc_checker

bind power_wake_control pwc_checker #(.PHYRST_MIN_CYC(PHYRST_MIN_CYC)) u_pwc_checker (.*);

// File: bench/tb_power_wake_control.sv
// Purpose: self-checking bench for power_wake_control
// Assumes: hold counts shortened to 20 and 60 cycles
// Notes: integer model tracks every control word field
`timescale 1ns/1ps
module tb_power_wake_control;
  localparam int HMIN = 20;
  localparam int HEXT = 60;
  logic core_clk_i = 0;
  logic rst_b_i = 0;
  logic light_reset_i = 0;
  logic [1:0] avs_address_i = 0;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic config_loading_i = 0;
  logic dev_unconfigured_i = 0;
  logic phy_operational_i = 1;
  logic crystal_default_i = 1;
  logic resume_by_device_i = 0;
  logic ready_o, phy_reset_o, crystal_sleep_disable_o;
  logic lan_wake_enable_o, phy_irq_wake_enable_o;
  logic [1:0] suspend_select_o;
  logic [4:0] ev = 0;
  wire resume_done_i = ev[0];
  wire phy_irq_event_i = ev[1];
  wire lan_frame_event_i = ev[2];
  wire energy_eff_rx_wake_i = ev[3];
  wire energy_eff_tx_wake_i = ev[4];
  int fail_count = 0, total_checks = 0, run_len = 0, last_len = 0;
  int m_susp = 2, m_en = 0, m_cause = 0, m_rdy = 0, m_busy = 1;
  logic [31:0] rdat, d;

  power_wake_control #(.PHYRST_MIN_CYC(HMIN), .PHYRST_EXT_CYC(HEXT)) u_power_wake_control (.*);

  initial forever #5 core_clk_i = ~core_clk_i;

  // length of each phy reset pulse
  always @(posedge core_clk_i)
    if (phy_reset_o === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
    end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input bit w, input logic [1:0] a, input logic [31:0] dw);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= dw;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_read_i <= 0;
    avs_write_i <= 0;
  endtask

  task automatic rd_ctrl;
    bus(0, 2'h0, 0);
    chk(rdat, {24'h0, m_rdy[0], m_susp[1:0], m_busy[0], m_en[1:0], m_cause[1:0]}, "ctrl");
  endtask

  // events are held 4 cycles so the synchronisers see them
  task automatic pulse(input int i);
    ev[i] <= 1;
    repeat (4) @(posedge core_clk_i);
    ev[i] <= 0;
    repeat (6) @(posedge core_clk_i);
  endtask

  task automatic wait_for(input bit rdy);
    for (int n = 0; n < 300 && (rdy ? ready_o !== 1'b1 : phy_reset_o !== 1'b0); n++)
      @(posedge core_clk_i);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100us;
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    rdat = $urandom(35);
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1;
    rd_ctrl;
    bus(0, 2'h1, 0);
    chk(rdat & 32'hFFFF_FFFB, 32'hA, "side");
    wait_for(1);
    m_busy = 0;
    m_rdy = 1;
    rd_ctrl;
    $display("reset test done");
    // short hold first, then the long analog reference wait
    for (int s = 1; s >= 0; s--)
    begin
      bus(1, 2'h1, 32'hA | (s << 2));
      phy_operational_i <= 0;
      bus(1, 2'h0, 32'h50);
      bus(1, 2'h0, 32'h40);
      m_busy = 1;
      m_rdy = 0;
      rd_ctrl;
      wait_for(0);
      @(posedge core_clk_i);
      chk(last_len, s ? HMIN : HEXT, "hold");
      repeat (6) @(posedge core_clk_i);
      rd_ctrl;
      phy_operational_i <= 1;
      wait_for(1);
      m_busy = 0;
      m_rdy = 1;
      rd_ctrl;
    end
    $display("phy reset test done");
    for (int e = 0; e < 4; e++)
    begin
      d = $urandom;
      d[7:0] = 8'h40 | (e << 2);
      bus(1, 2'h0, d);
      m_en = e;
      // enable register then output flop: the pins follow two edges later
      repeat (2) @(posedge core_clk_i);
      chk({lan_wake_enable_o, phy_irq_wake_enable_o}, e, "en");
      pulse(1);
      pulse(2);
      m_cause = m_cause | e;
      rd_ctrl;
      bus(1, 2'h0, d | 32'h1);
      m_cause = m_cause & 2;
      rd_ctrl;
    end
    $display("wake test done");
    bus(1, 2'h1, 32'h1A);
    pulse(1);
    m_cause = 3;
    pulse(0);
    rd_ctrl;
    resume_by_device_i <= 1;
    repeat (3) @(posedge core_clk_i);
    pulse(0);
    m_en = 0;
    m_cause = 1;
    rd_ctrl;
    // software restarts the phy after a resume from state two
    bus(1, 2'h0, 32'h50);
    repeat (3) @(posedge core_clk_i);
    chk(ready_o, 0, "ready drop");
    wait_for(1);
    rd_ctrl;
    $display("resume test done");
    for (int v = 0; v < 4; v++)
    begin
      bus(1, 2'h0, v << 5);
      m_susp = v;
      rd_ctrl;
      chk(suspend_select_o, v, "susp pin");
      for (int k = 4; k >= 3; k--)
      begin
        pulse(k);
        bus(0, 2'h1, 0);
        chk(rdat[0], k == 4 ? v == 3 : v != 2, "eflag");
        bus(1, 2'h1, 32'h1B);
      end
    end
    dev_unconfigured_i <= 1;
    repeat (6) @(posedge core_clk_i);
    m_susp = 2;
    rd_ctrl;
    bus(1, 2'h0, 32'h40);
    rd_ctrl;
    dev_unconfigured_i <= 0;
    repeat (4) @(posedge core_clk_i);
    bus(1, 2'h0, 32'hC0);
    bus(1, 2'h3, 32'hFF);
    // lane 0 disabled: the control word must not change
    avs_byteenable_i <= 4'hE;
    bus(1, 2'h0, 32'h60);
    avs_byteenable_i <= 4'hF;
    rd_ctrl;
    bus(0, 2'h2, 0);
    chk(rdat, 0, "unmapped");
    $display("suspend test done");
    config_loading_i <= 1;
    repeat (6) @(posedge core_clk_i);
    m_rdy = 0;
    rd_ctrl;
    config_loading_i <= 0;
    wait_for(1);
    chk(ready_o, 1, "ready");
    crystal_default_i <= 0;
    light_reset_i <= 1;
    repeat (2) @(posedge core_clk_i);
    light_reset_i <= 0;
    bus(0, 2'h1, 0);
    chk(rdat[1], 0, "xtal");
    chk(crystal_sleep_disable_o, 0, "xtal pin");
    $display("load test done");
    report_and_stop;
  end
endmodule // tb_power_wake_control
